/* File: core/flk_bus_cycle.sv */
`timescale 1ns/10ps
// Drives one strobe cycle on the flash pins: a write latched on the rising
// write strobe, or a status read with chip enable toggled before it.
module flk_bus_cycle
  import flk_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              start,
  input  wire flk_cyc_t          cyc,
  output logic                   done,
  output logic [7:0]             rdData,
  output logic                   chipEn_n,
  output logic                   writeEn_n,
  output logic                   outEn_n,
  output logic [ADDR_W-1:0]      addrOut,
  output logic [DATA_W-1:0]      dataOut,
  output logic                   dataOe,
  input  wire logic [7:0]        dataIn
);
  typedef enum logic [1:0] {BC_IDLE, BC_ACTIVE, BC_HIGH} flk_bc_t;
  typedef struct packed {
    flk_bc_t            st;
    logic [CNT_W-1:0]   cnt;
    flk_cyc_t           c;
    logic [7:0]         rd;
    logic [7:0]         s1;
    logic [7:0]         s2;
    logic               done;
  } flk_bc_state_t;
  flk_bc_state_t s_r, s_nxt;

  // Bus cycle sequencer; data pins pass two flops before use.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.s1 = dataIn;
    s_nxt.s2 = s_r.s1;
    case (s_r.st)
      BC_IDLE:
        if (start)
        begin
          s_nxt.c = cyc;
          s_nxt.st = BC_ACTIVE;
          s_nxt.cnt = cyc.read ? CNT_W'(T_ACCESS_CYC + 2) : CNT_W'(T_SETUP_CYC);
        end
      BC_ACTIVE:
        if (s_r.cnt == '0)
        begin
          if (s_r.c.read)
            s_nxt.rd = s_r.s2;
          s_nxt.st = BC_HIGH;
          s_nxt.cnt = CNT_W'(T_HIGH_CYC);
        end
        else
          s_nxt.cnt = s_r.cnt - 1'b1;
      default:
        if (s_r.cnt == '0)
        begin
          s_nxt.st = BC_IDLE;
          s_nxt.done = 1'b1;
        end
        else
          s_nxt.cnt = s_r.cnt - 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // Strobes go high between cycles, so each status read gets fresh data.
  // On a write, chip enable is held low through the high phase. The device
  // is then still selected when the write strobe rises and latches.
  assign chipEn_n  = !(s_r.st == BC_ACTIVE || (s_r.st == BC_HIGH && !s_r.c.read));
  assign writeEn_n = !(s_r.st == BC_ACTIVE && !s_r.c.read);
  assign outEn_n   = !(s_r.st == BC_ACTIVE && s_r.c.read);
  assign dataOe    = (s_r.st != BC_IDLE) && !s_r.c.read;
  assign addrOut   = s_r.c.addr;
  assign dataOut   = s_r.c.data;
  assign done      = s_r.done;
  assign rdData    = s_r.rd;
endmodule

/* File: core/flk_host_ctrl.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - Protect set is 57h then D0h at 0FFh.
// - Lock is 77h, D0h at block, after reset.
// - Two-byte write: FBh, first byte, second byte.
// - Lock wrapped by protect reset, then protect set.
// - Check ready before reading error flags; at POLL_MAX the flags are taken without it.
// - Probe writes FFh; bits 7,5,4 mean locked.
// - Toggle strobes between status reads.
// - Write FFh last to return to array.
// - Program zero only into bits leaving one.
// - Issue only defined command codes.
module flk_host_ctrl
  import flk_pkg::*;
#(
  parameter int POLL_MAX = 4095
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              reqValid,
  input  wire flk_req_t          req,
  input  wire logic [DATA_W-1:0] oldData,
  output logic                   reqReady,
  output logic                   respValid,
  output logic [7:0]             respStatus,
  output logic                   respLocked,
  output logic                   respSeqErr,
  output logic                   chipEn_n,
  output logic                   writeEn_n,
  output logic                   outEn_n,
  output logic                   byteMode_n,
  output logic                   reset_powerdown_n,
  output logic [ADDR_W-1:0]      addrOut,
  output logic                   a_m1Out,
  output logic                   a_m1Oe,
  output logic [DATA_W-1:0]      dataOut,
  output logic                   dataOe,
  input  wire logic [7:0]        dataIn,
  input  wire logic              ready_busy_n
);
  typedef enum logic [2:0] {HS_IDLE, HS_CYC, HS_WAIT, HS_POLL, HS_CLEAR, HS_DONE} flk_hs_t;
  typedef struct packed {
    flk_hs_t             st;
    flk_req_t            r;
    logic [1:0]          step;
    logic [11:0]         poll;
    logic [7:0]          status;
    logic                locked;
    logic                seqErr;
    logic                valid;
    logic                rp;
    logic                protOpen;
  } flk_host_state_t;
  flk_host_state_t s_r, s_nxt;

  logic      cycStart;
  flk_cyc_t  cyc;
  logic      cycDone;
  logic [7:0] cycRd;
  logic      rdySync;

  // Number of write cycles each command sequence uses.
  function automatic logic [1:0] seqLen(input flk_op_t op);
    case (op)
      OP_READ_ARRAY, OP_CLEAR_STATUS: seqLen = 2'd1;
      OP_TWO_BYTE:                    seqLen = 2'd3;
      default:                        seqLen = 2'd2;
    endcase
  endfunction

  // Only the defined codes are ever placed on the bus.
  function automatic flk_cyc_t cycFor(input flk_req_t r, input logic [1:0] step);
    flk_cyc_t c;
    c = '0;
    c.addr = r.addr;
    if (step == 2'd0)
    begin
      case (r.op)
        OP_READ_ARRAY:   c.data = DATA_W'(CMD_READ_ARRAY);
        OP_CLEAR_STATUS: c.data = DATA_W'(CMD_CLEAR_STATUS);
        OP_PROT_SET:     c.data = DATA_W'(CMD_PROT_SET);
        OP_PROT_RESET:   c.data = DATA_W'(CMD_PROT_RESET);
        OP_LOCK_BLOCK:   c.data = DATA_W'(CMD_LOCK_BLOCK);
        OP_ERASE_ALL:    c.data = DATA_W'(CMD_ERASE_ALL);
        OP_TWO_BYTE:     c.data = DATA_W'(CMD_TWO_BYTE);
        default:         c.data = DATA_W'(CMD_WRITE);
      endcase
    end
    else if (r.op == OP_PROT_SET || r.op == OP_PROT_RESET)
    begin
      c.addr[9:0] = PROT_CONF_ADDR;
      c.data = DATA_W'(CMD_CONFIRM);
    end
    else if (r.op == OP_LOCK_BLOCK || r.op == OP_ERASE_ALL)
      c.data = DATA_W'(CMD_CONFIRM);
    else if (r.op == OP_PROBE)
      c.data = DATA_W'(PROBE_DATA);
    else if (r.op == OP_TWO_BYTE)
      c.data = (r.hiFirst ^ (step == 2'd2)) ? {8'h00, r.data[15:8]}
                                             : {8'h00, r.data[7:0]};
    else
      c.data = ~(oldData & ~r.data);
    return c;
  endfunction

  assign cyc = (s_r.st == HS_POLL) ? flk_cyc_t'{addr: '0, data: '0, read: 1'b1}
             : (s_r.st == HS_CLEAR) ? flk_cyc_t'{addr: '0, data: DATA_W'(CMD_CLEAR_STATUS),
                                                   read: 1'b0}
             : cycFor(s_r.r, s_r.step);

  // Command sequencer: write cycles, busy wait, status poll, error clear.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.valid = 1'b0;
    s_nxt.rp = 1'b1;
    cycStart = 1'b0;
    case (s_r.st)
      HS_IDLE:
        if (reqValid)
        begin
          s_nxt.r = req;
          s_nxt.step = '0;
          s_nxt.st = HS_CYC;
          // Track the protect-reset window that a block lock needs.
          if (req.op == OP_PROT_RESET)
            s_nxt.protOpen = 1'b1;
          else if (req.op == OP_PROT_SET)
            s_nxt.protOpen = 1'b0;
        end
      HS_CYC:
      begin
        cycStart = 1'b1;
        s_nxt.st = HS_WAIT;
      end
      HS_WAIT:
        if (cycDone)
        begin
          if (s_r.step + 2'd1 < seqLen(s_r.r.op))
          begin
            s_nxt.step = s_r.step + 2'd1;
            s_nxt.st = HS_CYC;
          end
          else if (s_r.r.op == OP_READ_ARRAY || s_r.r.op == OP_CLEAR_STATUS)
            s_nxt.st = HS_DONE;
          else
          begin
            s_nxt.poll = '0;
            s_nxt.step = 2'd3;
            s_nxt.st = HS_POLL;
          end
        end
      HS_POLL:
      begin
        // Each read is its own strobe cycle so status refreshes.
        if (s_r.step == 2'd3)
        begin
          cycStart = 1'b1;
          s_nxt.step = 2'd0;
        end
        else if (cycDone)
        begin
          s_nxt.poll = s_r.poll + 12'd1;
          // Errors are judged once ready shows, or when the poll count reaches POLL_MAX.
          if ((cycRd[BIT_READY] && rdySync) || s_r.poll == 12'(POLL_MAX))
          begin
            s_nxt.status = cycRd;
            s_nxt.locked = (s_r.r.op == OP_PROBE) && cycRd[BIT_ERASE_ERR]
                           && cycRd[BIT_WRITE_ERR];
            s_nxt.seqErr = cycRd[BIT_ERASE_ERR] && cycRd[BIT_WRITE_ERR];
            s_nxt.step = 2'd3;
            s_nxt.st = (cycRd[BIT_ERASE_ERR] || cycRd[BIT_WRITE_ERR]
                        || cycRd[BIT_SUPPLY]) ? HS_CLEAR : HS_DONE;
          end
          else
            s_nxt.step = 2'd3;
        end
      end
      HS_CLEAR:
        // Error flags cleared before any further command.
        if (s_r.step == 2'd3)
        begin
          cycStart = 1'b1;
          s_nxt.step = 2'd0;
        end
        else if (cycDone)
          s_nxt.st = HS_DONE;
      default:
      begin
        s_nxt.valid = 1'b1;
        s_nxt.st = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  flk_bus_cycle u_cycle (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .start     (cycStart),
    .cyc       (cyc),
    .done      (cycDone),
    .rdData    (cycRd),
    .chipEn_n  (chipEn_n),
    .writeEn_n (writeEn_n),
    .outEn_n   (outEn_n),
    .addrOut   (addrOut),
    .dataOut   (dataOut),
    .dataOe    (dataOe),
    .dataIn    (dataIn)
  );

  flk_ready_sync u_rdy (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pinIn   (ready_busy_n),
    .level   (rdySync)
  );

  // Byte mode carries the byte-select bit; the first byte selects order.
  assign byteMode_n        = 1'b0;
  assign a_m1Out           = s_r.r.hiFirst;
  assign a_m1Oe            = dataOe;
  assign reset_powerdown_n = s_r.rp;
  assign reqReady          = (s_r.st == HS_IDLE);
  assign respValid         = s_r.valid;
  assign respStatus        = s_r.status;
  assign respLocked        = s_r.locked;
  assign respSeqErr        = s_r.seqErr;

  // Checks on the command sequences that are driven to the flash pins, and on the response flags.
  AST_CONF_ADDR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cycStart && s_r.st == HS_CYC && s_r.step == 2'd1
     && (s_r.r.op == OP_PROT_SET || s_r.r.op == OP_PROT_RESET))
    |=> (addrOut[9:0] == PROT_CONF_ADDR && dataOut[7:0] == CMD_CONFIRM))
    else $error("protect confirm address wrong");
  AST_SET_CODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cycStart && s_r.st == HS_CYC && s_r.step == 2'd0 && s_r.r.op == OP_PROT_SET)
    |=> dataOut[7:0] == CMD_PROT_SET)
    else $error("protect set code wrong");
  AST_RESET_CODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cycStart && s_r.st == HS_CYC && s_r.step == 2'd0 && s_r.r.op == OP_PROT_RESET)
    |=> dataOut[7:0] == CMD_PROT_RESET)
    else $error("protect reset code wrong");
  AST_TWO_BYTE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_r.st == HS_WAIT && cycDone && s_r.r.op == OP_TWO_BYTE && s_r.step != 2'd2)
    |=> s_r.st == HS_CYC)
    else $error("two-byte sequence cut short");
  AST_WE_STABLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(writeEn_n) |-> $past(dataOe) && dataOe)
    else $error("data not held at write strobe rise");
  AST_READ_TOGGLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(outEn_n) |-> $past(chipEn_n))
    else $error("status read without chip enable toggle");
  AST_SEQ_ERR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (respValid && respSeqErr) |-> respStatus[BIT_ERASE_ERR] && respStatus[BIT_WRITE_ERR])
    else $error("sequence error flag mismatch");
  AST_PROBE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (respValid && respLocked) |-> respStatus[BIT_READY])
    else $error("lock result without ready");
  // The lock order is checked here, not enforced; the caller owns the sequence.
  AST_LOCK_ORDER: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cycStart && s_r.st == HS_CYC && s_r.step == 2'd0 && s_r.r.op == OP_LOCK_BLOCK)
    |-> s_r.protOpen)
    else $error("block lock outside protect-reset window");
  AST_CLEAR_CODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cycStart && s_r.st == HS_CLEAR)
    |=> (!writeEn_n && dataOut[7:0] == CMD_CLEAR_STATUS))
    else $error("error clear write wrong");
  AST_SECOND_BYTE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cycStart && s_r.st == HS_CYC && s_r.r.op == OP_TWO_BYTE && s_r.step == 2'd2)
    |=> dataOut[7:0] == (s_r.r.hiFirst ? s_r.r.data[7:0] : s_r.r.data[15:8]))
    else $error("second byte of two-byte write wrong");
  AST_RP_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rst_n)
    |-> reset_powerdown_n)
    else $error("reset pin low outside reset");
endmodule

/* File: core/flk_pkg.sv */
package flk_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_WRITE        = 8'h40;
  localparam logic [7:0] CMD_PROT_SET     = 8'h57;
  localparam logic [7:0] CMD_PROT_RESET   = 8'h47;
  localparam logic [7:0] CMD_LOCK_BLOCK   = 8'h77;
  localparam logic [7:0] CMD_ERASE_ALL    = 8'ha7;
  localparam logic [7:0] CMD_TWO_BYTE     = 8'hfb;
  localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
  localparam logic [7:0] PROBE_DATA       = 8'hff;
  localparam logic [9:0] PROT_CONF_ADDR   = 10'h0ff;
  localparam int BIT_READY     = 7;
  localparam int BIT_SUSPENDED = 6;
  localparam int BIT_ERASE_ERR = 5;
  localparam int BIT_WRITE_ERR = 4;
  localparam int BIT_SUPPLY    = 3;
  // Strobe timing in ns; cycle counts derive from the 8 ns clock.
  localparam int CLK_NS      = 8;
  localparam int T_SETUP_NS  = 65;
  localparam int T_HIGH_NS   = 30;
  localparam int T_ACCESS_NS = 80;
  localparam int T_SETUP_CYC  = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_HIGH_CYC   = (T_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_ACCESS_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;

  typedef enum logic [3:0] {
    OP_READ_ARRAY, OP_CLEAR_STATUS, OP_PROT_SET, OP_PROT_RESET, OP_LOCK_BLOCK,
    OP_ERASE_ALL, OP_TWO_BYTE, OP_WRITE, OP_PROBE
  } flk_op_t;

  typedef struct packed {
    flk_op_t             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
    logic                hiFirst;
  } flk_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
    logic                read;
  } flk_cyc_t;
endpackage

/* File: core/flk_ready_sync.sv */
`timescale 1ns/10ps
// Brings the open-drain ready line into the clock domain with two flops.
module flk_ready_sync
  import flk_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   rst_n,
  input  wire logic   pinIn,
  output logic        level
);
  typedef struct packed {
    logic s1;
    logic s2;
  } flk_sync_t;
  flk_sync_t s_r, s_nxt;

  always_comb
  begin
    s_nxt.s1 = pinIn;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign level = s_r.s2;
endmodule

/* File: tb/flk_flash_model.sv */
`timescale 1ns/10ps
// Behavioural flash device in byte mode with lock protection and status.
module flk_flash_model
  import flk_pkg::*;
#(
  parameter int BUSY_NS = 600
)
(
  input  wire logic              chipEn_n,
  input  wire logic              writeEn_n,
  input  wire logic              outEn_n,
  input  wire logic              reset_powerdown_n,
  input  wire logic [ADDR_W-1:0] addrIn,
  input  wire logic              selIn,
  input  wire logic [7:0]        dataIn,
  output logic [7:0]             statusOut,
  output logic                   ready_busy_n
);
  logic [7:0]  mem [int];
  logic [31:0] lockBits  = '0;
  logic        allLocked = 1'b1;
  logic        protOn    = 1'b0;
  logic        readArray = 1'b1;
  logic        busy      = 1'b0;
  logic        firstSel  = 1'b0;
  logic [7:0]  pend      = 8'h00;
  logic [7:0]  stat      = 8'h00;
  logic [7:0]  shown     = 8'h80;
  logic [7:0]  lastProg  = 8'h00;
  logic [7:0]  firstByte = 8'h00;
  int          gone [$];
  event        kick;

  function automatic logic barred(input logic [4:0] b);
    return allLocked || (protOn && lockBits[b]);
  endfunction

  function automatic logic [7:0] cur(input int k);
    return mem.exists(k) ? mem[k] : 8'hff;
  endfunction

  // Commands and data are taken on the rising write strobe.
  always @(posedge writeEn_n)
  begin
    if (!chipEn_n && reset_powerdown_n)
    begin
      if (pend == 8'h00)
      begin
        readArray = (dataIn == CMD_READ_ARRAY);
        if (dataIn == CMD_CLEAR_STATUS)
          stat[5:3] = 3'b000;
        else if (dataIn != CMD_READ_ARRAY && dataIn != CMD_READ_STATUS)
          pend = dataIn;
      end
      else
      begin
        if (pend == CMD_WRITE || pend == CMD_TWO_BYTE)
        begin
          if (barred(addrIn[17:13]))
            stat[5:4] = 2'b11;
          else if (pend == CMD_WRITE)
          begin
            lastProg = dataIn;
            mem[int'({addrIn, selIn})] = cur(int'({addrIn, selIn})) & dataIn;
          end
          else
          begin
            firstSel  = selIn;
            firstByte = dataIn;
          end
        end
        else if (pend == 8'h01)
        begin
          mem[int'({addrIn, firstSel})]  = firstByte;
          mem[int'({addrIn, ~firstSel})] = dataIn;
        end
        else if (dataIn != CMD_CONFIRM ||
                 ((pend == CMD_PROT_SET || pend == CMD_PROT_RESET) &&
                  addrIn[9:0] != PROT_CONF_ADDR))
          stat[5:4] = 2'b11;
        else if (pend == CMD_PROT_SET)
        begin
          protOn    = 1'b1;
          allLocked = 1'b0;
        end
        else if (pend == CMD_PROT_RESET)
        begin
          protOn    = 1'b0;
          allLocked = 1'b0;
        end
        else if (pend == CMD_LOCK_BLOCK)
          lockBits[addrIn[17:13]] = 1'b1;
        else if (pend == CMD_ERASE_ALL)
        begin
          gone.delete();
          foreach (mem[k])
            if (!lockBits[k[18:14]])
              gone.push_back(k);
          foreach (gone[i])
            mem.delete(gone[i]);
        end
        pend = (pend == CMD_TWO_BYTE && stat[5:4] == 2'b00) ? 8'h01 : 8'h00;
        if (pend == 8'h00)
          ->kick;
      end
    end
  end

  // The machine stays busy for a while after each finished sequence of two or more cycles.
  always @(kick)
  begin
    busy = 1'b1;
    #BUSY_NS;
    busy = 1'b0;
  end

  // Status is refreshed only when the output strobe or chip enable falls.
  always @(negedge outEn_n or negedge chipEn_n)
    shown = {~busy, stat[6:0]};

  // The reset pin aborts everything and returns to the locked default.
  always @(negedge reset_powerdown_n)
  begin
    stat      = 8'h00;
    allLocked = 1'b1;
    protOn    = 1'b0;
    pend      = 8'h00;
    readArray = 1'b1;
    busy      = 1'b0;
  end

  // A released data bus shows the inverse of its last value.
  assign statusOut    = (!chipEn_n && !outEn_n) ? shown : ~shown;
  assign ready_busy_n = !busy;
endmodule

/* File: tb/tb_flk_host_ctrl.sv */
`timescale 1ns/10ps
`define CHK(what, exp, got) begin samplesChecked++; if ((got) !== (exp)) begin \
  $display("unexpected %s exp %h got %h", what, exp, got); miscompares++; end end
module tb_flk_host_ctrl
  import flk_pkg::*;
;
  logic ref_clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0;
  logic reqReady, respValid, respLocked, respSeqErr, ceN, weN, oeN, rpN, selOut, rdyN, byteN;
  logic [7:0] respStatus, devData;
  logic [ADDR_W-1:0] addrOut;
  logic [DATA_W-1:0] dataOut, oldData = '0;
  flk_req_t req = '0;
  int miscompares = 0, samplesChecked = 0, cycles = 0;

  flk_host_ctrl #(.POLL_MAX(20)) u_flk_host_ctrl (.ref_clk(ref_clk), .rst_n(rst_n),
    .reqValid(reqValid), .req(req), .oldData(oldData), .reqReady(reqReady),
    .respValid(respValid), .respStatus(respStatus), .respLocked(respLocked),
    .respSeqErr(respSeqErr), .chipEn_n(ceN), .writeEn_n(weN), .outEn_n(oeN),
    .byteMode_n(byteN), .reset_powerdown_n(rpN), .addrOut(addrOut), .a_m1Out(selOut),
    .a_m1Oe(), .dataOut(dataOut), .dataOe(), .dataIn(devData), .ready_busy_n(rdyN));

  flk_flash_model u_flk_flash_model (.chipEn_n(ceN), .writeEn_n(weN), .outEn_n(oeN),
    .reset_powerdown_n(rpN), .addrIn(addrOut), .selIn(selOut), .dataIn(dataOut[7:0]),
    .statusOut(devData), .ready_busy_n(rdyN));

  // Clock generation and the hang limit.
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      closeOut();
    end
  end

  task automatic closeOut();
    if (miscompares == 0 && samplesChecked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Offers one request and waits for its answer.
  task automatic runOp(input flk_op_t op, input logic [17:0] a, input logic [15:0] d,
                       input logic hi, input logic [15:0] old);
    int n;
    n = 0;
    @(posedge ref_clk);
    req <= '{op: op, addr: a, data: d, hiFirst: hi};
    oldData <= old;
    reqValid <= 1'b1;
    @(posedge ref_clk);
    reqValid <= 1'b0;
    while (respValid !== 1'b1 && n < 5000)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 5000)
    begin
      miscompares++;
      closeOut();
    end
  endtask

  task automatic lockedDefault();
    runOp(OP_WRITE, 18'h06000, 16'h0000, 1'b0, 16'h00ff);
    `CHK("refused", 1'b1, respSeqErr)
    `CHK("err bits", 2'b11, respStatus[5:4])
    `CHK("cleared", 3'b000, u_flk_flash_model.stat[5:3])
    `CHK("kept", 1'b0, 1'(u_flk_flash_model.mem.exists(int'({18'h06000, 1'b0}))))
  endtask

  task automatic lockAndProbe();
    runOp(OP_PROT_RESET, 18'h3ff00, 16'h0000, 1'b0, 16'h0000);
    `CHK("reset ok", 1'b0, respSeqErr)
    runOp(OP_WRITE, 18'h02000, 16'h00a5, 1'b0, 16'hffff);
    `CHK("prog", 8'ha5, u_flk_flash_model.lastProg)
    runOp(OP_TWO_BYTE, 18'h04010, 16'h5aa5, 1'b0, 16'h0000);
    `CHK("lo first", 1'b0, u_flk_flash_model.firstSel)
    `CHK("lo byte", 8'ha5, u_flk_flash_model.mem[int'({18'h04010, 1'b0})])
    runOp(OP_TWO_BYTE, 18'h04020, 16'hc33c, 1'b1, 16'h0000);
    `CHK("hi first", 1'b1, u_flk_flash_model.firstSel)
    `CHK("hi byte", 8'hc3, u_flk_flash_model.mem[int'({18'h04020, 1'b1})])
    runOp(OP_LOCK_BLOCK, 18'h02000, 16'h0000, 1'b0, 16'h0000);
    `CHK("lock bit", 1'b1, u_flk_flash_model.lockBits[1])
    runOp(OP_PROT_SET, 18'h00000, 16'h0000, 1'b0, 16'h0000);
    `CHK("set ok", 1'b0, respSeqErr)
    runOp(OP_PROBE, 18'h02000, 16'h0000, 1'b0, 16'h0000);
    `CHK("locked", 1'b1, respLocked)
    runOp(OP_PROBE, 18'h04000, 16'h0000, 1'b0, 16'h0000);
    `CHK("open", 8'h80, respStatus)
    runOp(OP_WRITE, 18'h04030, 16'h00bc, 1'b0, 16'h00bd);
    `CHK("over prog", 8'hfe, u_flk_flash_model.lastProg)
  endtask

  task automatic resetAndErase();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    `CHK("relocked", 1'b1, u_flk_flash_model.allLocked)
    `CHK("idle ready", 1'b1, reqReady)
    `CHK("byte mode", 1'b0, byteN)
    runOp(OP_ERASE_ALL, 18'h00000, 16'h0000, 1'b0, 16'h0000);
    `CHK("erased", 1'b0, 1'(u_flk_flash_model.mem.exists(int'({18'h04010, 1'b0}))))
    `CHK("lock kept", 1'b1, u_flk_flash_model.lockBits[1])
    runOp(OP_CLEAR_STATUS, 18'h00000, 16'h0000, 1'b0, 16'h0000);
    runOp(OP_READ_ARRAY, 18'h00000, 16'h0000, 1'b0, 16'h0000);
    `CHK("array mode", 1'b1, u_flk_flash_model.readArray)
  endtask

  // Main sequence.
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    lockedDefault();
    lockAndProbe();
    resetAndErase();
    closeOut();
  end
endmodule
